// ### verilog/sh_stream_pkg.sv
`default_nettype none
package sh_stream_pkg;
  localparam int PAY_W      = 64;
  localparam int BLK_W      = 66;
  localparam int MB_BLOCKS  = 32;
  localparam int CRC_W      = 12;
  localparam int FEC_W      = 26;
  localparam int CNT_W      = 8;

  typedef logic [1:0] mode_t;
  localparam mode_t MODE_CRC12 = 2'h0;
  localparam mode_t MODE_FEC   = 2'h2;

  // Koopman form, x^12 in bit 11; +1 term implicit
  localparam logic [11:0] CRC12_POLY = 12'h987;
  localparam logic [11:0] CRC12_TAPS = {CRC12_POLY[10:0], 1'b1};
  // x^21+x^17+x^9+x^4+1 below the x^26 term
  localparam logic [25:0] FEC_TAPS   = 26'h0220211;

  localparam logic [1:0]  HDR_ONE    = 2'h1;
  localparam logic [1:0]  HDR_ZERO   = 2'h2;
  localparam int          EOEMB_POS  = 22;
  localparam logic [4:0]  EOMB_PILOT = 5'h01;
  // Stream with zero parity, CRC layout, end bit clear
  localparam logic [31:0] SHS_RST    = 32'h80A88888;
  localparam logic [4:0]  LAST_BLK   = 5'h1F;

  localparam logic [7:0]  HDR_WIN    = 8'h40;
  localparam logic [7:0]  HDR_LIM    = 8'h04;
  localparam logic [7:0]  MB_WIN     = 8'h08;
  localparam logic [7:0]  MB_LIM     = 8'h03;
  localparam logic [7:0]  EMB_WIN    = 8'h08;
  localparam logic [7:0]  EMB_LIM    = 8'h03;

  function automatic logic [11:0] crc12_step(input logic [11:0] s,
                                             input logic [63:0] d);
    logic [11:0] c;
    logic        fb;
    c = s;
    for (int i = 63; i >= 0; i--) begin
      fb = d[i] ^ c[11];
      c  = {c[10:0], 1'b0} ^ ({12{fb}} & CRC12_TAPS);
    end
    return c;
  endfunction : crc12_step

  function automatic logic [25:0] fec_step(input logic [25:0] s,
                                           input logic [63:0] d);
    logic [25:0] c;
    logic        fb;
    c = s;
    for (int i = 63; i >= 0; i--) begin
      fb = d[i] ^ c[25];
      c  = {c[24:0], 1'b0} ^ ({26{fb}} & FEC_TAPS);
    end
    return c;
  endfunction : fec_step
endpackage : sh_stream_pkg
`default_nettype wire

// ### verilog/sh_link_if.sv
`default_nettype none
interface sh_link_if;
  logic [65:0] blk;
  logic        blk_valid;
  modport tx (output blk, output blk_valid);
  modport rx (input blk, input blk_valid);
endinterface : sh_link_if
`default_nettype wire

// ### verilog/sh_stream_tx.sv
`default_nettype none
module sh_stream_tx
  import sh_stream_pkg::*;
(
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  // Scrambled payload in
  input  wire logic [63:0]                pay_data,
  input  wire logic                       pay_valid,
  output logic                            pay_ready,
  // Configuration
  input  wire sh_stream_pkg::mode_t       header_stream_code_select,
  input  wire logic [sh_stream_pkg::CNT_W-1:0] emb_len,
  // Link
  sh_link_if.tx                           link,
  // Status
  output logic                            mb_start,
  output logic                            emb_last,
  output logic [sh_stream_pkg::FEC_W-1:0] parity_word
);
  import sh_stream_pkg::*;

  // Registered state
  logic [65:0]      blk_reg;
  logic             blk_valid_reg;
  logic             pay_ready_reg;
  logic             mb_start_reg;
  logic             emb_last_reg;
  logic [FEC_W-1:0] parity_word_reg;
  logic [4:0]       bcnt_reg;
  logic [4:0]       bcnt_next;
  logic [CNT_W-1:0] mbcnt_reg;
  logic [CNT_W-1:0] mbcnt_next;
  logic [CRC_W-1:0] crc_reg;
  logic [FEC_W-1:0] fec_reg;
  logic [31:0]      shs_reg;

  // Position decode
  wire              take      = pay_valid & pay_ready_reg;
  wire              first_blk = (bcnt_reg == 5'h00);
  wire              last_blk  = (bcnt_reg == LAST_BLK);
  wire              last_mb   = (mbcnt_reg == emb_len - CNT_W'(1));
  wire              eoemb_now = last_mb;

  // Generators restart from zero on the first block
  wire [CRC_W-1:0]  crc_base  = first_blk ? '0 : crc_reg;
  wire [FEC_W-1:0]  fec_base  = first_blk ? '0 : fec_reg;
  // Payload only, msb is the first transmitted bit
  wire [CRC_W-1:0]  crc_new   = crc12_step(crc_base, pay_data);
  wire [FEC_W-1:0]  fec_new   = fec_step(fec_base, pay_data);

  // Bit 22 is overlaid live from the extended count
  wire              shs_bit   = (bcnt_reg == 5'(EOEMB_POS)) ? eoemb_now
                                : shs_reg[bcnt_reg];
  wire [1:0]        hdr       = shs_bit ? HDR_ONE : HDR_ZERO;

  // Next stream word from the words just finished
  wire [31:0]       shs_next  = build_shs(header_stream_code_select,
                                          crc_new, fec_new);
  // Status copy of the finished word, check word zero-extended
  wire              fec_sel   = (header_stream_code_select == MODE_FEC);
  wire [FEC_W-1:0]  par_sel   = fec_sel ? fec_new
                                        : {14'h0000, crc_new};

  // Counters wrap at multiblock and extended ends
  assign bcnt_next  = last_blk ? 5'h00 : bcnt_reg + 5'h01;
  assign mbcnt_next = last_mb ? '0 : mbcnt_reg + CNT_W'(1);

  // Stream word layout for the selected code
  function automatic logic [31:0] build_shs(input mode_t m,
                                            input logic [11:0] c,
                                            input logic [25:0] f);
    logic [31:0] s;
    s = '0;
    if (m == MODE_FEC) begin
      // Parity 25..4 fill bits 0-21; bit 22 is the end bit
      for (int j = 0; j < 22; j++) begin
        s[j] = f[25-j];
      end
      // Parity 3..0 fill bits 23-26
      s[23] = f[3];
      s[24] = f[2];
      s[25] = f[1];
      s[26] = f[0];
    end else begin
      // Unsupported codes fall back to the check layout
      for (int g = 0; g < 4; g++) begin
        s[4*g]   = c[11-3*g];
        s[4*g+1] = c[10-3*g];
        s[4*g+2] = c[9-3*g];
        s[4*g+3] = 1'b1;
      end
      // Command positions 16-18, 20, 24-26 stay zero
      s[19] = 1'b1;
      s[21] = 1'b1;
      s[23] = 1'b1;
    end
    // End pilot, bit 27 first on the line
    s[31:27] = {EOMB_PILOT[0], EOMB_PILOT[1], EOMB_PILOT[2],
                EOMB_PILOT[3], EOMB_PILOT[4]};
    return s;
  endfunction : build_shs

  // Payload is always taken; no alignment sequence ahead of data
  // Ready rises one edge after reset and stays high
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pay_ready_reg <= 1'b0;
    end else begin
      pay_ready_reg <= 1'b1;
    end
  end

  // Block assembly: header bit from stream, then payload
  // Block holds between takes; valid marks each new one
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      blk_reg       <= '0;
      blk_valid_reg <= 1'b0;
    end else begin
      blk_valid_reg <= take;
      if (take) begin
        blk_reg <= {hdr, pay_data};
      end
    end
  end

  // Block and multiblock position
  // Multiblock count moves only on the last block
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bcnt_reg  <= 5'h00;
      mbcnt_reg <= '0;
    end else if (take) begin
      bcnt_reg <= bcnt_next;
      if (last_blk) begin
        mbcnt_reg <= mbcnt_next;
      end
    end
  end

  // Running generator state
  // Held across gaps so a pause splits no multiblock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      crc_reg <= '0;
      fec_reg <= '0;
    end else if (take) begin
      crc_reg <= crc_new;
      fec_reg <= fec_new;
    end
  end

  // Word finished in one multiblock is carried by the next
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shs_reg         <= SHS_RST;
      parity_word_reg <= '0;
    end else if (take && last_blk) begin
      shs_reg         <= shs_next;
      parity_word_reg <= par_sel;
    end
  end

  // Status pulses
  // One cycle each, per multiblock start or extended end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mb_start_reg <= 1'b0;
      emb_last_reg <= 1'b0;
    end else begin
      mb_start_reg <= take & first_blk;
      emb_last_reg <= take & last_blk & last_mb;
    end
  end

  // Outputs straight from registers
  assign pay_ready      = pay_ready_reg;
  assign link.blk       = blk_reg;
  assign link.blk_valid = blk_valid_reg;
  assign mb_start       = mb_start_reg;
  assign emb_last       = emb_last_reg;
  assign parity_word    = parity_word_reg;
endmodule : sh_stream_tx
`default_nettype wire

// ### verilog/sh_stream_rx.sv
`default_nettype none
module sh_stream_rx
  import sh_stream_pkg::*;
(
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  // Link
  sh_link_if.rx                           link,
  // Configuration
  input  wire sh_stream_pkg::mode_t       header_stream_code_select,
  input  wire logic [sh_stream_pkg::CNT_W-1:0] emb_len,
  input  wire logic [sh_stream_pkg::CNT_W-1:0] release_delay,
  // Released data
  output logic [63:0]                     data_out,
  output logic                            data_valid,
  // Status
  output logic                            aligned,
  output logic                            check_err,
  output logic                            syn_valid,
  output logic [sh_stream_pkg::FEC_W-1:0] syndrome,
  output logic                            block_lost,
  output logic                            sync_lost,
  output logic                            ref_pulse_req
);
  import sh_stream_pkg::*;

  typedef enum logic [2:0] {
    ST_HUNT  = 3'b001,
    ST_ALIGN = 3'b010,
    ST_REL   = 3'b100
  } rx_state_t;

  rx_state_t        st_reg, st_next;
  logic [31:0]      hist_reg;
  logic [4:0]       bcnt_reg;
  logic [CNT_W-1:0] mbcnt_reg;
  logic             emb_known_reg;
  logic             prev_ok_reg;
  logic             buf_reg;
  logic [15:0]      lemc_reg;
  logic [CRC_W-1:0] crc_reg, crc_prev_reg;
  logic [FEC_W-1:0] fec_reg, fec_prev_reg;
  logic [CNT_W-1:0] hwin_reg, herr_reg, mwin_reg, merr_reg;
  logic [CNT_W-1:0] ewin_reg, eerr_reg;
  logic [63:0]      data_reg;
  logic             dval_reg, cerr_reg, sval_reg;
  logic             blost_reg, slost_reg, ref_reg;
  logic [FEC_W-1:0] syn_reg;

  wire        v        = link.blk_valid;
  wire [1:0]  h        = link.blk[65:64];
  wire [63:0] d        = link.blk[63:0];
  wire        hb       = (h == HDR_ONE);
  wire        hbad     = (h != HDR_ONE) && (h != HDR_ZERO);
  wire [31:0] w        = {hist_reg[30:0], hb};
  wire [31:0] s        = {<<{w}};
  wire        pilot_ok = ({s[27], s[28], s[29], s[30], s[31]}
                          == EOMB_PILOT);
  wire        locked   = (st_reg != ST_HUNT);
  wire        last_blk = (bcnt_reg == LAST_BLK);
  wire        first    = (bcnt_reg == 5'h00);
  wire        last_mb  = (mbcnt_reg == emb_len - CNT_W'(1));
  wire        mb_end   = v & locked & last_blk;
  wire        emb_err  = mb_end & emb_known_reg & (s[EOEMB_POS] != last_mb);
  wire [CRC_W-1:0] crc_new = crc12_step(first ? '0 : crc_reg, d);
  wire [FEC_W-1:0] fec_new = fec_step(first ? '0 : fec_reg, d);
  wire [CRC_W-1:0] crc_rx  = {s[0], s[1], s[2], s[4], s[5], s[6],
                              s[8], s[9], s[10], s[12], s[13], s[14]};
  wire [FEC_W-1:0] fec_rx  = {s[0], s[1], s[2], s[3], s[4], s[5], s[6],
                              s[7], s[8], s[9], s[10], s[11], s[12],
                              s[13], s[14], s[15], s[16], s[17], s[18],
                              s[19], s[20], s[21], s[23], s[24], s[25],
                              s[26]};
  wire        hdr_drop = v & locked & hbad & (herr_reg == HDR_LIM - 8'h01);
  wire        mb_drop  = mb_end & ~pilot_ok & (merr_reg == MB_LIM - 8'h01);
  wire        emb_drop = emb_err & (eerr_reg == EMB_LIM - 8'h01);
  wire        any_drop = hdr_drop | mb_drop | emb_drop;
  wire [15:0] lemc_top = 16'({emb_len, 5'h00}) - 16'h0001;
  wire        emb_start = mb_end & emb_known_reg & last_mb;

  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      ST_HUNT:  if (v && pilot_ok && !hbad) st_next = ST_ALIGN;
      ST_ALIGN: if (buf_reg && lemc_reg == 16'(release_delay))
                  st_next = ST_REL;
      ST_REL:   st_next = ST_REL;
    endcase
    if (any_drop) st_next = ST_HUNT;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg <= ST_HUNT;
      // Ones, so no end pilot is seen before real headers
      hist_reg <= '1;
      bcnt_reg <= '0;
      mbcnt_reg <= '0;
      emb_known_reg <= 1'b0;
      buf_reg <= 1'b0;
    end else if (v) begin
      st_reg <= st_next;
      hist_reg <= w;
      bcnt_reg <= (st_reg == ST_HUNT) ? 5'h00 : bcnt_reg + 5'h01;
      if (!locked) emb_known_reg <= 1'b0;
      else if (mb_end) begin
        if (!emb_known_reg && s[EOEMB_POS]) emb_known_reg <= 1'b1;
        mbcnt_reg <= (last_mb || !emb_known_reg) ? '0
                     : mbcnt_reg + CNT_W'(1);
      end
      if (!locked || any_drop) buf_reg <= 1'b0;
      else if (emb_start) buf_reg <= 1'b1;
    end
  end

  // Free-running local extended multiblock clock, in blocks
  always_ff @(posedge clk) begin
    if (sys_rst) lemc_reg <= '0;
    else if (v) lemc_reg <= (lemc_reg >= lemc_top) ? '0
                            : lemc_reg + 16'h0001;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      crc_reg <= '0; fec_reg <= '0;
      crc_prev_reg <= '0; fec_prev_reg <= '0;
      prev_ok_reg <= 1'b0;
      cerr_reg <= 1'b0; sval_reg <= 1'b0; syn_reg <= '0;
    end else begin
      cerr_reg <= 1'b0;
      sval_reg <= 1'b0;
      if (v && locked) begin
        crc_reg <= crc_new;
        fec_reg <= fec_new;
      end
      if (!locked) prev_ok_reg <= 1'b0;
      else if (mb_end) begin
        crc_prev_reg <= crc_new;
        fec_prev_reg <= fec_new;
        prev_ok_reg <= 1'b1;
        if (prev_ok_reg && header_stream_code_select == MODE_FEC) begin
          syn_reg <= fec_prev_reg ^ fec_rx;
          sval_reg <= 1'b1;
        end else if (prev_ok_reg) begin
          cerr_reg <= (crc_prev_reg != crc_rx);
        end
      end
    end
  end

  // Error windows for header, pilot and end bit
  always_ff @(posedge clk) begin
    if (sys_rst || !locked) begin
      hwin_reg <= '0; herr_reg <= '0; mwin_reg <= '0;
      merr_reg <= '0; ewin_reg <= '0; eerr_reg <= '0;
    end else if (v) begin
      hwin_reg <= (hwin_reg == HDR_WIN - 8'h01) ? '0 : hwin_reg + 8'h01;
      if (hwin_reg == HDR_WIN - 8'h01) herr_reg <= '0;
      else if (hbad) herr_reg <= herr_reg + 8'h01;
      if (mb_end) begin
        mwin_reg <= (mwin_reg == MB_WIN - 8'h01) ? '0 : mwin_reg + 8'h01;
        if (mwin_reg == MB_WIN - 8'h01) merr_reg <= '0;
        else if (!pilot_ok) merr_reg <= merr_reg + 8'h01;
      end
      if (emb_start) begin
        ewin_reg <= (ewin_reg == EMB_WIN - 8'h01) ? '0 : ewin_reg + 8'h01;
        if (ewin_reg == EMB_WIN - 8'h01) eerr_reg <= '0;
      end
      if (emb_err) eerr_reg <= eerr_reg + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      data_reg <= '0; dval_reg <= 1'b0;
      blost_reg <= 1'b0; slost_reg <= 1'b0; ref_reg <= 1'b0;
    end else begin
      dval_reg <= v & (st_reg == ST_REL);
      if (v) data_reg <= d;
      blost_reg <= hdr_drop;
      slost_reg <= mb_drop | emb_drop;
      ref_reg <= mb_drop | emb_drop;
    end
  end

  assign data_out      = data_reg;
  assign data_valid    = dval_reg;
  assign aligned       = (st_reg == ST_REL);
  assign check_err     = cerr_reg;
  assign syn_valid     = sval_reg;
  assign syndrome      = syn_reg;
  assign block_lost    = blost_reg;
  assign sync_lost     = slost_reg;
  assign ref_pulse_req = ref_reg;
endmodule : sh_stream_rx
`default_nettype wire

// ### verification/sh_stream_chk.sv
`default_nettype none
module sh_stream_chk
  import sh_stream_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // Link signals
  input  wire logic [65:0]          blk,
  input  wire logic                 blk_valid,
  // Configuration
  input  wire sh_stream_pkg::mode_t header_stream_code_select,
  input  wire logic [7:0]           emb_len
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [4:0]  idx_reg;
  logic [7:0]  mb_reg;
  logic        first_reg;
  logic [30:0] sh_reg;
  wire  [1:0]  hdr      = blk[65:64];
  wire         last_mb  = (mb_reg == emb_len - 8'h01);
  wire         crc_mode = (header_stream_code_select != MODE_FEC);
  wire  [31:0] shs      = {blk[64], sh_reg};
  wire         mb_end   = blk_valid && (idx_reg == LAST_BLK);
  wire  [31:0] fixed    = SHS_RST | {9'h000, last_mb, 22'h000000};
  wire         cmd_pos  = idx_reg inside {5'h10, 5'h11, 5'h12, 5'h14,
                                          5'h18, 5'h19, 5'h1A};
  wire         one_pos  = idx_reg inside {5'h03, 5'h07, 5'h0B, 5'h0F,
                                          5'h13, 5'h15, 5'h17};

  // Block position, multiblock position, stream so far
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      idx_reg   <= 5'h00;
      mb_reg    <= 8'h00;
      first_reg <= 1'b1;
    end else if (blk_valid) begin
      idx_reg <= idx_reg + 5'h01;
      if (idx_reg < LAST_BLK)
        sh_reg[idx_reg] <= blk[64];
      if (mb_end) begin
        mb_reg    <= last_mb ? 8'h00 : mb_reg + 8'h01;
        first_reg <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  hdr_legal_a:
    assert property (blk_valid |-> hdr == HDR_ONE || hdr == HDR_ZERO)
    else $error("block header not a legal pattern");
  pilot_zero_a:
    assert property (blk_valid && idx_reg >= 5'h1B && idx_reg <= 5'h1E
                     |-> hdr == HDR_ZERO)
    else $error("pilot zero bit wrong");
  pilot_one_a:
    assert property (mb_end |-> hdr == HDR_ONE)
    else $error("pilot final one missing");
  eoemb_a:
    assert property (blk_valid && idx_reg == 5'h16
                     |-> hdr == (last_mb ? HDR_ONE : HDR_ZERO))
    else $error("extended end bit wrong");
  cmd_zero_a:
    assert property (blk_valid && crc_mode && cmd_pos |-> hdr == HDR_ZERO)
    else $error("command bit not zero");
  fixed_ones_a:
    assert property (blk_valid && crc_mode && one_pos |-> hdr == HDR_ONE)
    else $error("fixed one bit missing");
  crc_frame_a:
    assert property (mb_end && crc_mode |-> (shs & 32'hFFFF8888) == fixed)
    else $error("check layout frame wrong");
  first_mb_a:
    assert property (mb_end && first_reg |-> shs == fixed)
    else $error("first multiblock stream not empty word");
endmodule : sh_stream_chk
`default_nettype wire

// ### verification/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sh_stream_pkg::*;

  logic        clk = 1'b0, sys_rst = 1'b1, pay_valid = 1'b0;
  logic [63:0] pay_data = 64'h0, data_out;
  mode_t       mode = MODE_CRC12;
  logic [7:0]  emb_len = 8'h02, release_delay = 8'h00;
  logic        pay_ready, mb_start, emb_last, data_valid, aligned, check_err;
  logic        syn_valid, block_lost, sync_lost, ref_pulse_req;
  logic        check_err_b, syn_valid_b;
  logic [25:0] parity_word, syndrome, syndrome_b, exp_par [0:9];
  logic [31:0] cur;
  int          n_fail = 0, n_tests = 0, mbc = 0, idx = 0;
  int          c1, c2, bad, dv, nms, nel;

  sh_link_if u_sh_link_if();
  sh_link_if u_sh_link_if_b();
  // Second receiver sees one payload bit flipped
  assign u_sh_link_if_b.blk_valid = u_sh_link_if.blk_valid;
  assign u_sh_link_if_b.blk = u_sh_link_if.blk ^
                              ((mbc == 5 && idx == 3) ? 66'h400 : 66'h0);

  sh_stream_tx u_sh_stream_tx (.clk(clk), .sys_rst(sys_rst),
    .pay_data(pay_data), .pay_valid(pay_valid), .pay_ready(pay_ready),
    .header_stream_code_select(mode), .emb_len(emb_len),
    .link(u_sh_link_if), .mb_start(mb_start), .emb_last(emb_last),
    .parity_word(parity_word));
  sh_stream_rx u_sh_stream_rx (.clk(clk), .sys_rst(sys_rst),
    .link(u_sh_link_if), .header_stream_code_select(mode),
    .emb_len(emb_len), .release_delay(release_delay), .data_out(data_out),
    .data_valid(data_valid), .aligned(aligned), .check_err(check_err),
    .syn_valid(syn_valid), .syndrome(syndrome), .block_lost(block_lost),
    .sync_lost(sync_lost), .ref_pulse_req(ref_pulse_req));
  sh_stream_rx u_sh_stream_rx_b (.clk(clk), .sys_rst(sys_rst),
    .link(u_sh_link_if_b), .header_stream_code_select(mode),
    .emb_len(emb_len), .release_delay(release_delay), .data_out(),
    .data_valid(), .aligned(), .check_err(check_err_b),
    .syn_valid(syn_valid_b), .syndrome(syndrome_b), .block_lost(),
    .sync_lost(), .ref_pulse_req());
  sh_stream_chk u_sh_stream_chk (.clk(clk), .sys_rst(sys_rst),
    .blk(u_sh_link_if.blk), .blk_valid(u_sh_link_if.blk_valid),
    .header_stream_code_select(mode), .emb_len(emb_len));

  always #4 clk = ~clk;

  // Bitwise generators, first sent bit first
  function automatic logic [25:0] step(logic [25:0] s, logic [63:0] d,
                                       logic fec);
    for (int i = 63; i >= 0; i--) begin
      if (fec)
        s = {s[24:0], 1'b0} ^ ({26{d[i] ^ s[25]}} & 26'h0220211);
      else
        s[11:0] = {s[10:0], 1'b0} ^ ({12{d[i] ^ s[11]}} & 12'h30F);
    end
    return s;
  endfunction : step

  // Expected stream word, bit j from block j
  function automatic logic [31:0] build(mode_t m, logic [25:0] p,
                                        logic last);
    logic [31:0] s;
    int          k;
    s = 32'h80000000;
    s[22] = last;
    k = 11;
    if (m == MODE_FEC) begin
      for (int j = 0; j < 22; j++)
        s[j] = p[25 - j];
      for (int j = 23; j < 27; j++)
        s[j] = p[26 - j];
    end else begin
      for (int j = 0; j < 16; j++) begin
        if (j % 4 == 3) begin
          s[j] = 1'b1;
        end else begin
          s[j] = p[k];
          k--;
        end
      end
      s[19] = 1'b1;
      s[21] = 1'b1;
      s[23] = 1'b1;
    end
    return s;
  endfunction : build

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Stream monitor on the wire
  always @(negedge clk) begin
    if (sys_rst) begin
      mbc = 0;
      idx = 0;
    end else if (u_sh_link_if.blk_valid) begin
      cur[idx] = u_sh_link_if.blk[64];
      if (idx == 31) begin
        chk(cur, build(mbc == 0 ? MODE_CRC12 : mode, mbc == 0 ? 26'h0 :
            exp_par[mbc - 1], mbc % 2 == 1));
        mbc++;
        idx = 0;
      end else begin
        idx++;
      end
    end
  end

  // Receiver and status pulse counts
  always @(negedge clk) begin
    if (!sys_rst) begin
      if (mode == MODE_FEC ? syn_valid && syndrome != 26'h0 : check_err)
        c1++;
      if (mode == MODE_FEC ? syn_valid_b && syndrome_b != 26'h0 : check_err_b)
        c2++;
      if (block_lost || sync_lost || ref_pulse_req)
        bad++;
      if (data_valid) begin
        dv++;
        chk(data_out[63:32],
            (data_out[31:0] ^ 32'h7F4A7C15) * 32'h9E3779B9);
      end
      if (mb_start)
        nms++;
      if (emb_last)
        nel++;
    end
  end

  task run(input mode_t m);
    logic [25:0] p;
    mode = m;
    sys_rst = 1'b1;
    {c1, c2, bad, dv, nms, nel} = '0;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    for (int b = 0; b < 320; b++) begin
      pay_data = {b[31:0] * 32'h9E3779B9, b[31:0] ^ 32'h7F4A7C15};
      pay_valid = 1'b1;
      p = step(b % 32 == 0 ? 26'h0 : p, pay_data, m == MODE_FEC);
      if (b % 32 == 31)
        exp_par[b / 32] = p;
      @(negedge clk);
    end
    pay_valid = 1'b0;
    repeat (8) @(negedge clk);
    chk({6'h00, parity_word}, {6'h00, exp_par[9]});
    chk(pay_ready, 1'b1);
    chk(c1, 0);
    chk(c2, 1);
    chk(bad, 0);
    chk({aligned, dv != 0}, 2'h3);
    chk(nms, 10);
    chk(nel, 5);
    $display("test with code select %0d done", m);
  endtask : run

  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done

  initial begin
    run(MODE_CRC12);
    run(MODE_FEC);
    run(2'h1);
    test_done;
  end

  initial begin
    #100000;
    n_fail++;
    test_done;
  end
endmodule : testbench
`default_nettype wire
